// *** blic_defs.vh ***
// constants for the line interface configuration block
`ifndef BLIC_DEFS_VH
`define BLIC_DEFS_VH

// ----------------------------------------------------------------
// register indices and bus widths
// ----------------------------------------------------------------
`define BLIC_IDX_RX_CFG 8'h12
`define BLIC_IDX_LOOP_PWR 8'h13
`define BLIC_ADDR_W 8
`define BLIC_DATA_W 32
`define BLIC_REG_W 8

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define BLIC_RST_RX_CFG 8'h00
`define BLIC_RST_LOOP_PWR 8'h06
`define BLIC_MASK_RX_CFG 8'h7F
`define BLIC_MASK_LOOP_PWR 8'hBF

// ----------------------------------------------------------------
// field positions, line_rx_config
// ----------------------------------------------------------------
`define BLIC_TERM_ON 6
`define BLIC_IMP_HI 5
`define BLIC_IMP_LO 4
`define BLIC_RATIO 3
`define BLIC_MON_EN 2
`define BLIC_SENS_HI 1
`define BLIC_SENS_LO 0

// ----------------------------------------------------------------
// field positions, line_loop_power_config
// ----------------------------------------------------------------
`define BLIC_ALARM 7
`define BLIC_LOCAL_LOOP 5
`define BLIC_ANALOG_LOOP 4
`define BLIC_REMOTE_LOOP 3
`define BLIC_TX_PD 2
`define BLIC_RX_PD 1
`define BLIC_TX_EN 0

// ----------------------------------------------------------------
// line modes and clock source code
// ----------------------------------------------------------------
`define BLIC_MODE_DS1 2'h0
`define BLIC_MODE_E1 2'h1
`define BLIC_MODE_2048 2'h2
`define BLIC_MODE_6312 2'h3
`define BLIC_CLKSRC_RX 4'hE

// ----------------------------------------------------------------
// sensitivity table, gain in dB, loss in half dB
// ----------------------------------------------------------------
`define BLIC_GAIN_W 6
`define BLIC_LOSS_W 8
`define BLIC_LOSS_12 8'h18
`define BLIC_LOSS_17P5 8'h23
`define BLIC_LOSS_18 8'h24
`define BLIC_LOSS_22P5 8'h2D
`define BLIC_LOSS_30 8'h3C
`define BLIC_LOSS_36 8'h48
`define BLIC_LOSS_43 8'h56
`define BLIC_LOSS_2048_OFS 8'h10
`define BLIC_GAIN_0 6'h00
`define BLIC_GAIN_14 6'h0E
`define BLIC_GAIN_20 6'h14
`define BLIC_GAIN_26 6'h1A
`define BLIC_GAIN_32 6'h20

`endif

// *** blic_line_model.sv ***
// far-end line model: drives the receive pair, reads the transmit pair
`timescale 1ns/1ps
module blic_line_model (
   // clock
   input wire clock_i,
   // bench control and transmit pair
   input wire mark_i,
   input wire tx_pos_i,
   input wire tx_neg_i,
   input wire tx_pos_oe_i,
   input wire tx_neg_oe_i,
   // receive pair and line as seen
   output reg rx_pos_o = 1'b0,
   output reg rx_neg_o = 1'b0,
   output wire line_pos_o,
   output wire line_neg_o
);
   // bipolar marks, never both legs at once
   always @(posedge clock_i) begin
      rx_pos_o <= mark_i;
      rx_neg_o <= !mark_i;
   end
   // undriven pair reads zero across the transformer
   assign line_pos_o = tx_pos_oe_i ? tx_pos_i : 1'b0;
   assign line_neg_o = tx_neg_oe_i ? tx_neg_i : 1'b0;
endmodule

// *** blic_sens.v ***
// receiver sensitivity and monitor gain decode, registered
`timescale 1ns/1ps
`include "blic_defs.vh"
module blic_sens (
   // clock and reset
   input wire clock_i,
   input wire rstn_i,
   // settings
   input wire [1:0] line_mode_i,
   input wire monitor_i,
   input wire [1:0] sel_i,
   // decoded values
   output reg [`BLIC_GAIN_W-1:0] gain_db_o,
   output reg [`BLIC_LOSS_W-1:0] loss_hdb_o
);
   reg [`BLIC_GAIN_W-1:0] gain_d;
   reg [`BLIC_LOSS_W-1:0] loss_d;

   always @* begin
      gain_d = `BLIC_GAIN_0;
      loss_d = `BLIC_LOSS_12;
      case ({monitor_i, sel_i})
         3'h0: loss_d = `BLIC_LOSS_12;
         3'h1: loss_d = `BLIC_LOSS_18;
         3'h2: loss_d = `BLIC_LOSS_30;
         3'h3: begin
            if (line_mode_i == `BLIC_MODE_DS1)
               loss_d = `BLIC_LOSS_36;
            else
               loss_d = `BLIC_LOSS_43;
         end
         3'h4: begin
            gain_d = `BLIC_GAIN_14;
            loss_d = `BLIC_LOSS_30;
         end
         3'h5: begin
            gain_d = `BLIC_GAIN_20;
            loss_d = `BLIC_LOSS_22P5;
         end
         3'h6: begin
            gain_d = `BLIC_GAIN_26;
            loss_d = `BLIC_LOSS_17P5;
         end
         default: begin
            gain_d = `BLIC_GAIN_32;
            loss_d = `BLIC_LOSS_12;
         end
      endcase
      // 2048 kHz receiver is about 8 dB less sensitive
      if (line_mode_i == `BLIC_MODE_2048)
         loss_d = loss_d - `BLIC_LOSS_2048_OFS;
      if (line_mode_i == `BLIC_MODE_6312) begin
         gain_d = `BLIC_GAIN_0;
         loss_d = {`BLIC_LOSS_W{1'b0}};
      end
   end

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gain_db_o <= {`BLIC_GAIN_W{1'b0}};
         loss_hdb_o <= {`BLIC_LOSS_W{1'b0}};
      end else begin
         gain_db_o <= gain_d;
         loss_hdb_o <= loss_d;
      end
   end
endmodule

// *** blic_sync.v ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module blic_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire clock_i,
   input wire rstn_i,
   // data
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta_q;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= {W{1'b0}};
         q_o <= {W{1'b0}};
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

// *** blic_top.v ***
// line interface configuration registers and line path steering
`timescale 1ns/1ps
`include "blic_defs.vh"
// Operation
// - termination bit off leaves receive pins high impedance; on terminates
// - impedance field codes 75, 100, 110, 120 ohms; always programmed
// - ratio bit selects 1:1 or 2:1 receive transformer
// - monitor enable works except in 6312 kHz mode
// - sensitivity field ignored in 6312 kHz mode
// - monitor off: codes allow 12, 18, 30, 36/43 dB loss
// - monitor on: gain 14..32 dB, loss 30, 22.5, 17.5, 12 dB
// - 2048 kHz allowed loss is about 8 dB below E1
// - alarm bit sends unframed all ones in DS1 or E1 only
// - local loop feeds formatter to framer, line still transmits
// - analog loop feeds transmitter output into line receiver
// - remote loop drives transmitter from receiver output
// - clock source code 1110 sends recovered clock to transmit clock
// - transmit power-down resets to 1 and floats transmit pins
// - receive power-down resets to 1 until software clears it
// - driver enable resets to 0; active needs high-z pins low
module blic_top (
   // clock and reset
   input wire clock_i,
   input wire rstn_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`BLIC_ADDR_W-1:0] paddr_i,
   input wire [`BLIC_DATA_W-1:0] pwdata_i,
   output reg [`BLIC_DATA_W-1:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // mode and clock selection from neighbouring logic
   input wire [1:0] line_mode_i,
   input wire [3:0] tx_clock_source_select_i,
   input wire tx_clock_sel_i,
   input wire rx_rec_clock_i,
   // transmit formatter side
   input wire tx_fmt_pos_i,
   input wire tx_fmt_neg_i,
   // line pins
   input wire rx_line_pos_i,
   input wire rx_line_neg_i,
   input wire tx_hiz_pin_a_i,
   input wire tx_hiz_pin_b_i,
   output reg tx_line_pos_o,
   output reg tx_line_neg_o,
   output reg tx_line_pos_oe_o,
   output reg tx_line_neg_oe_o,
   output reg tx_line_clock_o,
   // receive framer side
   output reg rx_framer_pos_o,
   output reg rx_framer_neg_o,
   // analog front end controls
   output reg rx_term_enable_o,
   output reg [1:0] rx_cable_impedance_o,
   output reg rx_transformer_ratio_o,
   output reg rx_monitor_active_o,
   output reg [1:0] rx_sensitivity_select_o,
   output reg [`BLIC_GAIN_W-1:0] rx_monitor_gain_db_o,
   output reg [`BLIC_LOSS_W-1:0] rx_max_loss_hdb_o,
   output reg tx_powered_o,
   output reg rx_powered_o
);
   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function [`BLIC_ADDR_W-1:0] byte_addr;
      input [`BLIC_ADDR_W-1:0] idx;
      begin
         byte_addr = {idx[`BLIC_ADDR_W-3:0], 2'h0};
      end
   endfunction

   // monitor and sensitivity only act outside 6312 kHz
   function not_6312;
      input [1:0] mode;
      begin
         not_6312 = (mode != `BLIC_MODE_6312);
      end
   endfunction

   // all-ones alarm exists only in the framed modes
   function alarm_mode;
      input [1:0] mode;
      begin
         alarm_mode = (mode == `BLIC_MODE_DS1) | (mode == `BLIC_MODE_E1);
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg rst_meta_q;
   reg rst_q;
   wire rstn;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q <= rst_meta_q;
      end
   end

   assign rstn = rst_q;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire [3:0] pins_s;

   blic_sync #(
      .W(4)
   ) u_pin_sync (
      .clock_i(clock_i),
      .rstn_i(rstn),
      .d_i({rx_line_pos_i, rx_line_neg_i, tx_hiz_pin_a_i, tx_hiz_pin_b_i}),
      .q_o(pins_s)
   );

   wire rx_pos_s = pins_s[3];
   wire rx_neg_s = pins_s[2];
   wire hiz_a_s = pins_s[1];
   wire hiz_b_s = pins_s[0];

   // ----------------------------------------------------------------
   // apb slave, no wait states
   // ----------------------------------------------------------------
   reg [`BLIC_REG_W-1:0] rx_cfg_q;
   reg [`BLIC_REG_W-1:0] loop_pwr_q;
   wire hit_rx = (paddr_i == byte_addr(`BLIC_IDX_RX_CFG));
   wire hit_lp = (paddr_i == byte_addr(`BLIC_IDX_LOOP_PWR));
   wire setup = psel_i & ~penable_i & ~pready_o;
   wire wr_done = psel_i & penable_i & pready_o & pwrite_i;
   reg [`BLIC_DATA_W-1:0] rdata_d;

   always @* begin
      rdata_d = {`BLIC_DATA_W{1'b0}};
      if (hit_rx)
         rdata_d = {24'h000000, rx_cfg_q};
      else if (hit_lp)
         rdata_d = {24'h000000, loop_pwr_q};
   end

   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= {`BLIC_DATA_W{1'b0}};
      end else begin
         pready_o <= setup;
         if (setup) begin
            pslverr_o <= ~(hit_rx | hit_lp);
            prdata_o <= pwrite_i ? {`BLIC_DATA_W{1'b0}} : rdata_d;
         end else if (pready_o) begin
            pslverr_o <= 1'b0;
            prdata_o <= {`BLIC_DATA_W{1'b0}};
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         rx_cfg_q <= `BLIC_RST_RX_CFG;
         loop_pwr_q <= `BLIC_RST_LOOP_PWR;
      end else if (wr_done) begin
         if (hit_rx)
            rx_cfg_q <= pwdata_i[`BLIC_REG_W-1:0] & `BLIC_MASK_RX_CFG;
         if (hit_lp)
            loop_pwr_q <= pwdata_i[`BLIC_REG_W-1:0] & `BLIC_MASK_LOOP_PWR;
      end
   end

   wire mode_ok = not_6312(line_mode_i);
   wire mon_eff = rx_cfg_q[`BLIC_MON_EN] & mode_ok;
   wire alarm_eff = loop_pwr_q[`BLIC_ALARM] & alarm_mode(line_mode_i);
   wire local_loop_enable = loop_pwr_q[`BLIC_LOCAL_LOOP];
   wire analog_loop_enable = loop_pwr_q[`BLIC_ANALOG_LOOP];
   wire remote_loop_enable = loop_pwr_q[`BLIC_REMOTE_LOOP];
   wire tx_pd = loop_pwr_q[`BLIC_TX_PD];
   wire rx_pd = loop_pwr_q[`BLIC_RX_PD];

   // ----------------------------------------------------------------
   // sensitivity decode
   // ----------------------------------------------------------------
   wire [`BLIC_GAIN_W-1:0] gain_w;
   wire [`BLIC_LOSS_W-1:0] loss_w;

   blic_sens u_sens (
      .clock_i(clock_i),
      .rstn_i(rstn),
      .line_mode_i(line_mode_i),
      .monitor_i(mon_eff),
      .sel_i(rx_cfg_q[`BLIC_SENS_HI:`BLIC_SENS_LO]),
      .gain_db_o(gain_w),
      .loss_hdb_o(loss_w)
   );

   // ----------------------------------------------------------------
   // line data paths
   // ----------------------------------------------------------------
   reg ais_phase_q;
   reg rcv_pos_q;
   reg rcv_neg_q;
   // registered stages keep analog and remote loops from closing
   // a combinational ring when both are set
   wire rin_pos = analog_loop_enable ? tx_line_pos_o : rx_pos_s;
   wire rin_neg = analog_loop_enable ? tx_line_neg_o : rx_neg_s;
   wire src_pos = alarm_eff ? ais_phase_q : tx_fmt_pos_i;
   wire src_neg = alarm_eff ? ~ais_phase_q : tx_fmt_neg_i;

   // ----------------------------------------------------------------
   // alarm pattern
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         ais_phase_q <= 1'b0;
      end else begin
         // alternating marks give all ones on a bipolar line
         ais_phase_q <= ~ais_phase_q;
      end
   end

   // ----------------------------------------------------------------
   // receive stage
   // ----------------------------------------------------------------
   // power-down gates the line receiver only, not the local loop
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         rcv_pos_q <= 1'b0;
         rcv_neg_q <= 1'b0;
      end else begin
         rcv_pos_q <= rin_pos & ~rx_pd;
         rcv_neg_q <= rin_neg & ~rx_pd;
      end
   end

   // ----------------------------------------------------------------
   // transmit line
   // ----------------------------------------------------------------
   // remote loop wins over the alarm pattern
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         tx_line_pos_o <= 1'b0;
         tx_line_neg_o <= 1'b0;
      end else begin
         tx_line_pos_o <= remote_loop_enable ? rcv_pos_q : src_pos;
         tx_line_neg_o <= remote_loop_enable ? rcv_neg_q : src_neg;
      end
   end

   // ----------------------------------------------------------------
   // framer input
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         rx_framer_pos_o <= 1'b0;
         rx_framer_neg_o <= 1'b0;
      end else begin
         rx_framer_pos_o <= local_loop_enable ? src_pos : rcv_pos_q;
         rx_framer_neg_o <= local_loop_enable ? src_neg : rcv_neg_q;
      end
   end

   // ----------------------------------------------------------------
   // transmit clock
   // ----------------------------------------------------------------
   // resampled, so the selected clock lags its source by one cycle
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         tx_line_clock_o <= 1'b0;
      end else if (tx_clock_source_select_i == `BLIC_CLKSRC_RX) begin
         tx_line_clock_o <= rx_rec_clock_i;
      end else begin
         tx_line_clock_o <= tx_clock_sel_i;
      end
   end

   // ----------------------------------------------------------------
   // driver enables
   // ----------------------------------------------------------------
   // both high-z pins must be low before the driver turns on
   wire drive = loop_pwr_q[`BLIC_TX_EN] & ~tx_pd & ~hiz_a_s & ~hiz_b_s;

   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         tx_line_pos_oe_o <= 1'b0;
         tx_line_neg_oe_o <= 1'b0;
      end else begin
         tx_line_pos_oe_o <= drive;
         tx_line_neg_oe_o <= drive;
      end
   end

   // ----------------------------------------------------------------
   // receive front end controls
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         rx_term_enable_o <= 1'b0;
         rx_cable_impedance_o <= 2'h0;
         rx_transformer_ratio_o <= 1'b0;
         rx_monitor_active_o <= 1'b0;
         rx_sensitivity_select_o <= 2'h0;
         rx_monitor_gain_db_o <= {`BLIC_GAIN_W{1'b0}};
         rx_max_loss_hdb_o <= {`BLIC_LOSS_W{1'b0}};
      end else begin
         rx_term_enable_o <= rx_cfg_q[`BLIC_TERM_ON];
         rx_cable_impedance_o <= rx_cfg_q[`BLIC_IMP_HI:`BLIC_IMP_LO];
         rx_transformer_ratio_o <= rx_cfg_q[`BLIC_RATIO];
         rx_monitor_active_o <= mon_eff;
         if (mode_ok)
            rx_sensitivity_select_o <=
               rx_cfg_q[`BLIC_SENS_HI:`BLIC_SENS_LO];
         else
            rx_sensitivity_select_o <= 2'h0;
         rx_monitor_gain_db_o <= gain_w;
         rx_max_loss_hdb_o <= loss_w;
      end
   end

   // ----------------------------------------------------------------
   // power status
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn) begin
      if (!rstn) begin
         tx_powered_o <= 1'b0;
         rx_powered_o <= 1'b0;
      end else begin
         tx_powered_o <= ~tx_pd;
         rx_powered_o <= ~rx_pd;
      end
   end
endmodule

// *** blic_top_properties.sv ***
// assertions on the ports of the line configuration block
`timescale 1ns/1ps
module blic_top_properties (
   // clock and reset
   input wire clock_i,
   input wire rstn_i,
   // apb
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // line side
   input wire [1:0] line_mode_i,
   input wire [3:0] tx_clock_source_select_i,
   input wire rx_rec_clock_i,
   input wire tx_hiz_pin_a_i,
   input wire tx_hiz_pin_b_i,
   input wire tx_line_pos_oe_o,
   input wire tx_line_clock_o,
   input wire rx_monitor_active_o,
   input wire [1:0] rx_sensitivity_select_o,
   input wire [7:0] rx_max_loss_hdb_o,
   input wire tx_powered_o
);
   reg [2:0] live_q;
   wire live;
   // outputs sit at zero for a few edges after reset
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i)
         live_q <= 3'h0;
      else if (live_q != 3'h7)
         live_q <= live_q + 3'h1;
   end
   assign live = live_q == 3'h7;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ------
   // assertions
   // ------
   chk_ready_setup: assert property (
      live && psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   chk_err_unmapped: assert property (
      pready_o && paddr_i != 8'h48 && paddr_i != 8'h4C
      |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
      else $error("unmapped access not refused");
   chk_read_zero: assert property (
      pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0
      && !(paddr_i == 8'h48 && prdata_o[7])
      && !(paddr_i == 8'h4C && prdata_o[6]))
      else $error("unassigned bit reads one");
   chk_tx_float: assert property (
      !tx_powered_o |-> !tx_line_pos_oe_o)
      else $error("driver on while powered down");
   chk_hiz_pins: assert property (
      live && tx_line_pos_oe_o
      |-> !$past(tx_hiz_pin_a_i, 3) && !$past(tx_hiz_pin_b_i, 3))
      else $error("driver on with hiz pin high");
   chk_clk_recov: assert property (
      live && $past(tx_clock_source_select_i) == 4'hE
      |-> tx_line_clock_o == $past(rx_rec_clock_i))
      else $error("recovered clock not passed");
   chk_mode_gate: assert property (
      live && $past(line_mode_i) == 2'h3
      |-> !rx_monitor_active_o && rx_sensitivity_select_o == 2'h0)
      else $error("monitor active in top mode");
   chk_loss_ds1: assert property (
      (live && line_mode_i == 2'h0 && !rx_monitor_active_o
      && $stable(rx_sensitivity_select_o)) [*5]
      |-> rx_max_loss_hdb_o == (rx_sensitivity_select_o == 2'h0 ? 8'h18
      : rx_sensitivity_select_o == 2'h1 ? 8'h24
      : rx_sensitivity_select_o == 2'h2 ? 8'h3C : 8'h48))
      else $error("wrong allowed loss");
endmodule
bind blic_top blic_top_properties blic_top_properties_inst (
   .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .line_mode_i(line_mode_i),
   .tx_clock_source_select_i(tx_clock_source_select_i),
   .rx_rec_clock_i(rx_rec_clock_i), .tx_hiz_pin_a_i(tx_hiz_pin_a_i),
   .tx_hiz_pin_b_i(tx_hiz_pin_b_i), .tx_line_pos_oe_o(tx_line_pos_oe_o),
   .tx_line_clock_o(tx_line_clock_o),
   .rx_monitor_active_o(rx_monitor_active_o),
   .rx_sensitivity_select_o(rx_sensitivity_select_o),
   .rx_max_loss_hdb_o(rx_max_loss_hdb_o), .tx_powered_o(tx_powered_o));

// *** testbench.sv ***
// self-checking bench for the line configuration block
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0, rstn = 1'b0, sel = 1'b0, en = 1'b0, we = 1'b0;
   reg [7:0] adr = 8'h00;
   reg [31:0] wd = 32'h0, got, ex;
   reg [1:0] md = 2'h0;
   reg [3:0] cs = 4'h0;
   reg tck = 1'b0, rck = 1'b0, fp = 1'b0, fn = 1'b0, hz = 1'b1;
   reg mk = 1'b0, err, a;
   wire [31:0] rd;
   wire rdy, serr, txp, txn, oep, oen, lck, frp, frn, trm, rat, mon;
   wire txpw, rxpw, rxp, rxn, lnp, lnn;
   wire [1:0] imp, sns;
   wire [5:0] gain;
   wire [7:0] loss;
   integer fails = 0, check_count = 0, cyc = 0, i;
   // loss per {monitor, sensitivity}, half dB
   localparam [63:0] loss_tab = 64'h18243C483C2D2318;
   always #10 clk = ~clk;
   // free-running recovered and normal transmit clocks
   always @(posedge clk) begin
      rck <= ~rck;
      tck <= rck;
   end
   blic_top blic_top_inst (
      .clock_i(clk), .rstn_i(rstn), .psel_i(sel), .penable_i(en),
      .pwrite_i(we), .paddr_i(adr), .pwdata_i(wd), .prdata_o(rd),
      .pready_o(rdy), .pslverr_o(serr), .line_mode_i(md),
      .tx_clock_source_select_i(cs), .tx_clock_sel_i(tck),
      .rx_rec_clock_i(rck), .tx_fmt_pos_i(fp), .tx_fmt_neg_i(fn),
      .rx_line_pos_i(rxp), .rx_line_neg_i(rxn), .tx_hiz_pin_a_i(hz),
      .tx_hiz_pin_b_i(hz), .tx_line_pos_o(txp), .tx_line_neg_o(txn),
      .tx_line_pos_oe_o(oep), .tx_line_neg_oe_o(oen),
      .tx_line_clock_o(lck), .rx_framer_pos_o(frp),
      .rx_framer_neg_o(frn), .rx_term_enable_o(trm),
      .rx_cable_impedance_o(imp), .rx_transformer_ratio_o(rat),
      .rx_monitor_active_o(mon), .rx_sensitivity_select_o(sns),
      .rx_monitor_gain_db_o(gain), .rx_max_loss_hdb_o(loss),
      .tx_powered_o(txpw), .rx_powered_o(rxpw));
   blic_line_model blic_line_model_inst (.clock_i(clk), .mark_i(mk),
      .tx_pos_i(txp), .tx_neg_i(txn), .tx_pos_oe_i(oep),
      .tx_neg_oe_i(oen), .rx_pos_o(rxp), .rx_neg_o(rxn),
      .line_pos_o(lnp), .line_neg_o(lnn));
   // ------
   // tasks
   // ------
   task chk(input [31:0] s, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("ERROR %0t got %h want %h", $time, s, e);
         end
      end
   endtask
   task w(input [7:0] n);
      repeat (n) @(negedge clk);
   endtask
   // one apb transfer, held until ready is seen
   task bus(input wr, input [7:0] ad, input [31:0] d);
      begin
         @(posedge clk);
         sel <= 1'b1;
         we <= wr;
         adr <= ad;
         wd <= d;
         @(posedge clk);
         en <= 1'b1;
         @(posedge clk);
         // ready ends this wait; with no ready only the run timeout does
         while (rdy !== 1'b1)
            @(posedge clk);
         chk(rdy, 1);
         got = rd;
         err = serr;
         sel <= 1'b0;
         en <= 1'b0;
      end
   endtask
   task wr(input [7:0] ad, input [31:0] d);
      begin
         bus(1'b1, ad, d);
         w(8);
      end
   endtask
   task rdc(input [7:0] ad, input [31:0] e);
      begin
         bus(1'b0, ad, 32'h0);
         chk(got, e);
         w(1);
      end
   endtask
   task pins(input [1:0] m, input [3:0] c, input p, input q, input h,
      input k);
      begin
         @(posedge clk);
         md <= m;
         cs <= c;
         fp <= p;
         fn <= q;
         hz <= h;
         mk <= k;
         w(8);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", check_count, fails);
         if (fails == 0 && check_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         $display("ERROR %0t run timed out", $time);
         end_sim;
      end
   end
   // ------
   // tests
   // ------
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      w(4);
      rdc(8'h48, 32'h00);
      rdc(8'h4C, 32'h06);
      chk({txpw, rxpw, oep, oen}, 0);
      wr(8'h48, 32'hFFFFFFFF);
      rdc(8'h48, 32'h7F);
      chk({trm, imp, rat, mon, sns}, 32'h7F);
      wr(8'h4C, 32'hFFFFFFFF);
      rdc(8'h4C, 32'hBF);
      bus(1'b1, 8'h50, 32'hFF);
      chk(err, 1);
      rdc(8'h50, 32'h0);
      chk(err, 1);
      wr(8'h48, 32'h20);
      chk({trm, imp, rat}, 32'h4);
      $display("register test done");
      for (i = 0; i < 32; i = i + 1) begin
         pins(i[4:3], 4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
         wr(8'h48, i[2:0]);
         ex = (loss_tab >> (8 * (7 - i[2:0]))) & 32'hFF;
         if (i[4:3] != 2'h0 && i[2:0] == 3'h3)
            ex = 32'h56;
         if (i[4:3] == 2'h2)
            ex = ex - 32'h10;
         if (i[4:3] == 2'h3)
            ex = 32'h0;
         chk(loss, ex);
         chk(mon, i[2] && i[4:3] != 2'h3);
         chk(sns, i[4:3] == 2'h3 ? 2'h0 : i[1:0]);
         if (i[4:3] != 2'h3)
            chk(gain, i[2] ? 32'hE + 32'h6 * i[1:0] : 0);
      end
      $display("sensitivity test done");
      pins(2'h0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b1);
      wr(8'h4C, 32'h01);
      chk({oep, oen, txpw, rxpw}, 32'hF);
      chk({txp, txn, lnp, lnn, frp, frn}, 32'h2A);
      pins(2'h0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1);
      chk({oep, oen, lnp, lnn}, 32'h0);
      pins(2'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      // local, analog, remote, local with remote
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h4C, (32'h21110929 >> (8 * (3 - i))) & 32'hFF);
         ex = (16'h55A9 >> (4 * (3 - i))) & 4'hF;
         chk({txp, txn, frp, frn}, ex);
      end
      wr(8'h4C, 32'h81);
      a = txp;
      w(1);
      chk({txp ^ txn, txp}, {1'b1, ~a});
      pins(2'h2, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      chk({txp, txn}, 32'h1);
      pins(2'h0, 4'hE, 1'b0, 1'b1, 1'b0, 1'b1);
      chk(lck, {~rck});
      pins(2'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      chk(lck, rck);
      $display("line test done");
      wr(8'h4C, 32'h05);
      chk({oep, txpw, rxpw}, 32'h1);
      wr(8'h4C, 32'h03);
      chk({frp, frn, rxpw, txpw}, 32'h1);
      $display("power test done");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      w(4);
      rdc(8'h4C, 32'h06);
      rdc(8'h48, 32'h00);
      $display("reset test done");
      end_sim;
   end
endmodule
